//--- hw/spc_eeprom.sv
`timescale 1ns/1ps
`default_nettype none
module spc_eeprom #(
	parameter int ADDR_BITS      = spc_pkg::ADDR_BITS,
	parameter int PROGRAM_CYCLES = spc_pkg::PROGRAM_CYCLES
) (
	input  wire logic                 clock,
	input  wire logic                 sys_rst,
	input  wire spc_pkg::spc_pins_t   pins,
	output logic                      serial_out,
	output logic                      serial_out_oe,
	output logic                      write_enabled,
	output logic                      busy,
	input  wire logic [ADDR_BITS-1:0] peek_addr,
	output logic      [15:0]          peek_data
);
	initial begin
		if (ADDR_BITS < 6 || ADDR_BITS > 8 || PROGRAM_CYCLES < 2) begin
			$error("spc_eeprom: unsupported ADDR_BITS or PROGRAM_CYCLES");
		end
	end

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_OP   = 5'h02,
		ST_ADDR = 5'h04,
		ST_DATA = 5'h08,
		ST_HOLD = 5'h10
	} spc_state_t;

	// Pin synchronisers: stage one feeds only stage two
	spc_pkg::spc_pins_t pin_meta;
	spc_pkg::spc_pins_t pin_sync;
	logic               cs_q;
	logic               sk_q;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pin_meta <= '0;
			pin_sync <= '0;
			cs_q     <= 1'b0;
			sk_q     <= 1'b0;
		end else begin
			pin_meta <= pins;
			pin_sync <= pin_meta;
			cs_q     <= pin_sync.chip_select;
			sk_q     <= pin_sync.serial_clock;
		end
	end

	logic cs;
	logic di;
	logic sk_rise;
	logic cs_fall;
	assign cs      = pin_sync.chip_select;
	assign di      = pin_sync.serial_in;
	assign sk_rise = cs && pin_sync.serial_clock && !sk_q;
	assign cs_fall = cs_q && !cs;

	// Frame decoder
	spc_state_t           state;
	spc_state_t           next_state;
	logic [1:0]           opcode;
	logic [1:0]           next_opcode;
	logic [ADDR_BITS-1:0] addr_sh;
	logic [ADDR_BITS-1:0] next_addr_sh;
	logic [15:0]          data_sh;
	logic [15:0]          next_data_sh;
	logic [4:0]           bit_cnt;
	logic [4:0]           next_bit_cnt;
	logic                 next_write_enabled;
	logic                 start_seen;
	logic                 latch_evt;
	logic                 frame_ok;
	logic                 guarded_now;

	spc_pkg::spc_prog_req_t req_in;
	spc_pkg::spc_prog_req_t req_out;
	logic                   fifo_in_ready;
	logic                   fifo_out_valid;
	logic                   fifo_out_ready;
	logic                   prog_active;

	// Input is locked out while any programming is pending or running
	assign busy       = prog_active || fifo_out_valid;
	assign start_seen = sk_rise && !busy && state == ST_IDLE && di;

	always_comb begin
		next_state         = state;
		next_opcode        = opcode;
		next_addr_sh       = addr_sh;
		next_data_sh       = data_sh;
		next_bit_cnt       = bit_cnt;
		next_write_enabled = write_enabled;
		latch_evt          = 1'b0;
		if (!cs) begin
			next_state   = ST_IDLE;
			next_bit_cnt = '0;
		end else if (sk_rise && !busy) begin
			unique case (state)
				ST_IDLE: begin
					// Low serial_in here is a dummy clock
					if (di) begin
						next_state   = ST_OP;
						next_bit_cnt = '0;
					end
				end
				ST_OP: begin
					next_opcode  = {opcode[0], di};
					next_bit_cnt = bit_cnt + 5'h01;
					if (bit_cnt == 5'h01) begin
						next_state   = ST_ADDR;
						next_bit_cnt = '0;
					end
				end
				ST_ADDR: begin
					next_addr_sh = {addr_sh[ADDR_BITS-2:0], di};
					next_bit_cnt = bit_cnt + 5'h01;
					if (bit_cnt == 5'(ADDR_BITS - 1)) begin
						next_bit_cnt = '0;
						next_state   = (opcode == spc_pkg::OP_WRITE) ?
							ST_DATA : ST_HOLD;
						if (opcode == spc_pkg::OP_SPECIAL) begin
							latch_evt = 1'b1;
							if (next_addr_sh[ADDR_BITS-1 -: 2] ==
								spc_pkg::KEY_ENABLE) begin
								next_write_enabled = 1'b1;
							end else if (next_addr_sh[ADDR_BITS-1 -: 2] ==
								spc_pkg::KEY_DISABLE) begin
								next_write_enabled = 1'b0;
							end
						end
					end
				end
				ST_DATA: begin
					// Older bits fall off the top of the shifter
					next_data_sh = {data_sh[14:0], di};
					if (bit_cnt != 5'(spc_pkg::WORD_BITS)) begin
						next_bit_cnt = bit_cnt + 5'h01;
					end
				end
				ST_HOLD: begin
					next_state = ST_HOLD;
				end
				default: begin
					next_state = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state         <= ST_IDLE;
			opcode        <= '0;
			addr_sh       <= '0;
			data_sh       <= '0;
			bit_cnt       <= '0;
			write_enabled <= spc_pkg::LATCH_RESET;
		end else begin
			state         <= next_state;
			opcode        <= next_opcode;
			addr_sh       <= next_addr_sh;
			data_sh       <= next_data_sh;
			bit_cnt       <= next_bit_cnt;
			write_enabled <= next_write_enabled;
		end
	end

	// Frame commit on deselect; a refused or short frame is simply dropped
	always_comb begin
		guarded_now = !pin_sync.write_guard_pin &&
			!addr_sh[ADDR_BITS-1];
		frame_ok = cs_fall && write_enabled && fifo_in_ready &&
			((state == ST_DATA && bit_cnt == 5'(spc_pkg::WORD_BITS)) ||
			(state == ST_HOLD && opcode == spc_pkg::OP_ERASE));
		req_in.erase   = opcode == spc_pkg::OP_ERASE;
		req_in.guarded = guarded_now;
		req_in.addr    = addr_sh;
		req_in.data    = data_sh;
	end

	spc_fifo #(
		.WIDTH ($bits(spc_pkg::spc_prog_req_t)),
		.DEPTH (spc_pkg::FIFO_DEPTH)
	) u_fifo (
		.clock     (clock),
		.sys_rst   (sys_rst),
		.in_valid  (frame_ok),
		.in_ready  (fifo_in_ready),
		.in_data   (req_in),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (req_out)
	);

	// Programming engine
	spc_pkg::spc_prog_req_t cur;
	spc_pkg::spc_prog_req_t next_cur;
	logic [31:0]            prog_count;
	logic [31:0]            next_prog_count;
	logic                   next_prog_active;
	logic                   mem_we;
	logic [15:0]            mem_wdata;
	logic [15:0]            mem [2**ADDR_BITS];

	assign fifo_out_ready = !prog_active;

	always_comb begin
		next_cur         = cur;
		next_prog_active = prog_active;
		next_prog_count  = prog_count;
		mem_we           = 1'b0;
		// Erase forces ones; write lands directly with no pre-erase
		mem_wdata        = cur.erase ? spc_pkg::ERASED_WORD : cur.data;
		if (prog_active) begin
			next_prog_count = prog_count + 32'h1;
			if (prog_count == 32'(PROGRAM_CYCLES - 1)) begin
				next_prog_active = 1'b0;
				next_prog_count  = '0;
				mem_we           = !cur.guarded;
			end
		end else if (fifo_out_valid) begin
			next_cur         = req_out;
			next_prog_active = 1'b1;
			next_prog_count  = '0;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cur         <= '0;
			prog_active <= 1'b0;
			prog_count  <= '0;
		end else begin
			cur         <= next_cur;
			prog_active <= next_prog_active;
			prog_count  <= next_prog_count;
		end
	end

	// Array contents survive reset, as nonvolatile cells would
	always_ff @(posedge clock) begin
		if (mem_we) begin
			mem[cur.addr] <= mem_wdata;
		end
		peek_data <= mem[peek_addr];
	end

	// Busy/ready output
	logic verify;
	logic next_verify;
	logic next_so;
	logic next_oe;

	always_comb begin
		next_verify = verify;
		if (frame_ok) begin
			next_verify = 1'b1;
		end else if (start_seen) begin
			next_verify = 1'b0;
		end
		next_oe = cs && next_verify && !start_seen;
		next_so = !busy;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			verify        <= 1'b0;
			serial_out    <= 1'b0;
			serial_out_oe <= 1'b0;
		end else begin
			verify        <= next_verify;
			serial_out    <= next_so;
			serial_out_oe <= next_oe;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	sequence s_frame_drop;
		frame_ok;
	endsequence
	sequence s_engine_runs;
		##[1:3] prog_active;
	endsequence

	property p_start_on_drop;
		s_frame_drop |-> s_engine_runs;
	endproperty
	a_start_on_drop: assert property (p_start_on_drop)
		else $error("programming did not start after frame end");

	property p_prog_bound;
		prog_count < 32'(PROGRAM_CYCLES);
	endproperty
	a_prog_bound: assert property (p_prog_bound)
		else $error("programming exceeded its time");

	property p_busy_low;
		serial_out_oe && $past(prog_active) |-> !serial_out;
	endproperty
	a_busy_low: assert property (p_busy_low)
		else $error("serial_out not low while busy");

	property p_ready_high;
		serial_out_oe && !$past(busy) |-> serial_out;
	endproperty
	a_ready_high: assert property (p_ready_high)
		else $error("serial_out not high when ready");

	property p_ignore_busy;
		busy && cs |=> state == ST_IDLE;
	endproperty
	a_ignore_busy: assert property (p_ignore_busy)
		else $error("frame decoder advanced while programming");

	property p_start_hiz;
		start_seen |=> !serial_out_oe;
	endproperty
	a_start_hiz: assert property (p_start_hiz)
		else $error("serial_out still driven after start bit");

	property p_erase_ones;
		mem_we && cur.erase |-> mem_wdata == spc_pkg::ERASED_WORD;
	endproperty
	a_erase_ones: assert property (p_erase_ones)
		else $error("erase did not write all ones");

	property p_guard;
		prog_active && cur.guarded |-> !mem_we;
	endproperty
	a_guard: assert property (p_guard)
		else $error("guarded word was written");

	property p_cs_low_idle;
		!cs |=> state == ST_IDLE && !serial_out_oe;
	endproperty
	a_cs_low_idle: assert property (p_cs_low_idle)
		else $error("activity while chip_select low");

	property p_latch_stable;
		$changed(write_enabled) |-> $past(latch_evt);
	endproperty
	a_latch_stable: assert property (p_latch_stable)
		else $error("write latch changed without a latch command");
endmodule // spc_eeprom
`default_nettype wire

//--- pkg/spc_pkg.sv
package spc_pkg;

	localparam logic [1:0]  OP_READ      = 2'h2;
	localparam logic [1:0]  OP_WRITE     = 2'h1;
	localparam logic [1:0]  OP_ERASE     = 2'h3;
	localparam logic [1:0]  OP_SPECIAL   = 2'h0;
	localparam logic [1:0]  KEY_ENABLE   = 2'h3;
	localparam logic [1:0]  KEY_DISABLE  = 2'h0;

	localparam int          WORD_BITS    = 16;
	localparam int          ADDR_BITS    = 8;
	localparam logic [15:0] ERASED_WORD  = 16'hffff;
	localparam logic        LATCH_RESET  = 1'b0;
	localparam int          FIFO_DEPTH   = 32;

	localparam longint      CLOCK_HZ        = 200_000_000;
	localparam longint      PROGRAM_TIME_MS = 10;
	localparam int          PROGRAM_CYCLES  =
		int'(PROGRAM_TIME_MS * CLOCK_HZ / 1000);

	typedef struct packed {
		logic                 erase;
		logic                 guarded;
		logic [ADDR_BITS-1:0] addr;
		logic [WORD_BITS-1:0] data;
	} spc_prog_req_t;

	typedef struct packed {
		logic chip_select;
		logic serial_clock;
		logic serial_in;
		logic write_guard_pin;
	} spc_pins_t;

endpackage

//--- hw/spc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module spc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic             clock,
	input  wire logic             sys_rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
			$error("spc_fifo: DEPTH must be a power of two >= 2");
		end
	end

	logic [WIDTH-1:0] store [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	logic [AW:0]      next_wr_ptr;
	logic [AW:0]      next_rd_ptr;
	logic             push;
	logic             pop;

	assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
	assign out_valid = wr_ptr != rd_ptr;
	assign out_data  = store[rd_ptr[AW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
		end
	end

	// Storage needs no reset; only pointers define what is valid
	always_ff @(posedge clock) begin
		if (push) begin
			store[wr_ptr[AW-1:0]] <= in_data;
		end
	end
endmodule // spc_fifo
`default_nettype wire

//--- verification/spc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spc_host_model (
	input  wire logic              clock,
	output var spc_pkg::spc_pins_t pins
);
	// Half of the 125 ns link period in 5 ns clocks
	localparam int HALF = 12;
	initial pins = '0;
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic set_cs(input logic v);
		pins.chip_select <= v;
	endtask
	// Held steady from frame entry to the end of programming
	task automatic set_guard(input logic v);
		pins.write_guard_pin <= v;
	endtask
	// Clock runs only inside frames; data moves while the clock is low
	task automatic link_bit(input logic b);
		pins.serial_in <= b;
		wait_clk(HALF);
		pins.serial_clock <= 1'b1;
		wait_clk(HALF + 1);
		pins.serial_clock <= 1'b0;
	endtask
	// Sends the last nd bits of data; nd above 16 overfills a write
	task automatic frame(input logic [1:0] op, input logic [7:0] addr,
		input int nd, input logic [19:0] data);
		set_cs(1'b1);
		wait_clk(HALF);
		link_bit(1'b0);
		link_bit(1'b0);
		link_bit(1'b1);
		for (int i = 1; i >= 0; i--) link_bit(op[i]);
		for (int i = 7; i >= 0; i--) link_bit(addr[i]);
		for (int i = nd - 1; i >= 0; i--) link_bit(data[i]);
		pins.serial_in <= 1'b0;
		wait_clk(HALF);
		set_cs(1'b0);
		wait_clk(HALF);
	endtask
endmodule // spc_host_model
`default_nettype wire

//--- verification/spc_eeprom_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module spc_eeprom_tb_top;
	// Short programming time keeps the run small; bounds derive from it
	localparam int PCYC = 2000;
	logic               clock;
	logic               sys_rst;
	spc_pkg::spc_pins_t pins;
	logic               serial_out;
	logic               serial_out_oe;
	logic               write_enabled;
	logic               busy;
	logic [7:0]         peek_addr;
	logic [15:0]        peek_data;
	int                 error_cnt;
	int                 samples_checked;

	spc_eeprom #(.ADDR_BITS(8), .PROGRAM_CYCLES(PCYC)) spc_eeprom_inst (
		.clock(clock), .sys_rst(sys_rst), .pins(pins),
		.serial_out(serial_out), .serial_out_oe(serial_out_oe),
		.write_enabled(write_enabled), .busy(busy),
		.peek_addr(peek_addr), .peek_data(peek_data));
	spc_host_model spc_host_model_inst (.clock(clock), .pins(pins));

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [19:0] seen, input logic [19:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic peek(input logic [7:0] a, input logic [15:0] exp);
		peek_addr <= a;
		spc_host_model_inst.wait_clk(3);
		check(peek_data, exp);
	endtask

	task automatic cmd(input logic [1:0] op, input logic [7:0] a,
		input int nd, input logic [19:0] d);
		spc_host_model_inst.frame(op, a, nd, d);
	endtask

	// Holds select high and waits for ready; n returns the wait
	task automatic poll_hold(output int n);
		n = 0;
		spc_host_model_inst.set_cs(1'b1);
		spc_host_model_inst.wait_clk(8);
		check(serial_out_oe, 1'b1);
		check(serial_out, 1'b0);
		while (serial_out !== 1'b1 && n < PCYC + 100) begin
			spc_host_model_inst.wait_clk(1);
			n++;
		end
		check(serial_out, 1'b1);
		spc_host_model_inst.link_bit(1'b1);
		check(serial_out_oe, 1'b0);
		spc_host_model_inst.set_cs(1'b0);
		spc_host_model_inst.wait_clk(12);
	endtask

	task automatic t_latch();
		int n;
		check(write_enabled, 1'b0);
		check(serial_out_oe, 1'b0);
		cmd(spc_pkg::OP_SPECIAL, {spc_pkg::KEY_ENABLE, 6'h0}, 0, 0);
		check(write_enabled, 1'b1);
		cmd(spc_pkg::OP_ERASE, 8'h85, 0, 0);
		poll_hold(n);
		peek(8'h85, spc_pkg::ERASED_WORD);
		cmd(spc_pkg::OP_SPECIAL, {spc_pkg::KEY_DISABLE, 6'h3f}, 0, 0);
		check(write_enabled, 1'b0);
		cmd(spc_pkg::OP_WRITE, 8'h85, 16, 20'h01234);
		check(busy, 1'b0);
		peek(8'h85, spc_pkg::ERASED_WORD);
		$display("t_latch done");
	endtask

	task automatic t_write();
		int n;
		cmd(spc_pkg::OP_SPECIAL, {spc_pkg::KEY_ENABLE, 6'h2a}, 0, 0);
		cmd(spc_pkg::OP_WRITE, 8'h85, 16, 20'h01234);
		poll_hold(n);
		check(write_enabled, 1'b1);
		cmd(spc_pkg::OP_WRITE, 8'h85, 16, 20'h04321);
		poll_hold(n);
		peek(8'h85, 16'h4321);
		cmd(spc_pkg::OP_WRITE, 8'h85, 20, 20'ha5a5c);
		poll_hold(n);
		peek(8'h85, 16'h5a5c);
		cmd(spc_pkg::OP_READ, 8'h85, 0, 0);
		check(write_enabled, 1'b1);
		$display("t_write done");
	endtask

	// Pulsed polling, plus a frame sent while programming runs
	task automatic t_busy();
		int   n;
		logic rdy;
		n = 0;
		cmd(spc_pkg::OP_WRITE, 8'h86, 16, 20'h00f0f);
		cmd(spc_pkg::OP_ERASE, 8'h86, 0, 0);
		check(busy, 1'b1);
		// Output is only meaningful while selected, so sample it then
		do begin
			spc_host_model_inst.set_cs(1'b1);
			spc_host_model_inst.wait_clk(8);
			check(serial_out_oe, 1'b1);
			rdy = serial_out;
			spc_host_model_inst.set_cs(1'b0);
			spc_host_model_inst.wait_clk(12);
			n++;
		end while (rdy !== 1'b1 && n < PCYC / 20 + 10);
		check(busy, 1'b0);
		peek(8'h86, 16'h0f0f);
		cmd(spc_pkg::OP_ERASE, 8'h86, 0, 0);
		poll_hold(n);
		peek(8'h86, spc_pkg::ERASED_WORD);
		$display("t_busy done");
	endtask

	task automatic t_guard();
		int n;
		spc_host_model_inst.set_guard(1'b1);
		cmd(spc_pkg::OP_WRITE, 8'h05, 16, 20'h01111);
		poll_hold(n);
		spc_host_model_inst.set_guard(1'b0);
		cmd(spc_pkg::OP_WRITE, 8'h05, 16, 20'h02222);
		poll_hold(n);
		check(n > PCYC - 100, 1'b1);
		peek(8'h05, 16'h1111);
		cmd(spc_pkg::OP_ERASE, 8'h05, 0, 0);
		poll_hold(n);
		peek(8'h05, 16'h1111);
		cmd(spc_pkg::OP_WRITE, 8'h85, 16, 20'h03333);
		poll_hold(n);
		peek(8'h85, 16'h3333);
		$display("t_guard done");
	endtask

	// Select dropped after eight data bits ends the frame unexecuted
	task automatic t_abort();
		cmd(spc_pkg::OP_WRITE, 8'h85, 8, 20'h000aa);
		check(busy, 1'b0);
		peek(8'h85, 16'h3333);
		cmd(spc_pkg::OP_SPECIAL, {spc_pkg::KEY_DISABLE, 6'h0}, 0, 0);
		check(write_enabled, 1'b0);
		$display("t_abort done");
	endtask

	// A committed request crosses the queue with address and data intact
	task automatic t_fifo();
		int n;
		cmd(spc_pkg::OP_SPECIAL, {spc_pkg::KEY_ENABLE, 6'h0}, 0, 0);
		check(write_enabled, 1'b1);
		cmd(spc_pkg::OP_WRITE, 8'hc3, 16, 20'h0beef);
		check(busy, 1'b1);
		poll_hold(n);
		check(n < PCYC, 1'b1);
		peek(8'hc3, 16'hbeef);
		cmd(spc_pkg::OP_ERASE, 8'hc3, 0, 0);
		check(busy, 1'b1);
		poll_hold(n);
		peek(8'hc3, spc_pkg::ERASED_WORD);
		cmd(spc_pkg::OP_SPECIAL, {spc_pkg::KEY_DISABLE, 6'h0}, 0, 0);
		check(write_enabled, 1'b0);
		$display("t_fifo done");
	endtask

	initial begin
		sys_rst = 1'b1;
		peek_addr = 8'h00;
		error_cnt = 0;
		samples_checked = 0;
		repeat (8) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clock);
		t_latch();
		t_write();
		t_busy();
		t_guard();
		t_abort();
		t_fifo();
		summarize();
	end

	// About two and a half times the expected run
	initial begin
		#450us;
		error_cnt++;
		summarize();
	end
endmodule // spc_eeprom_tb_top
`default_nettype wire
